// *** core/clock_manager_phase_status.sv ***
// Clock manager: reset and lock, phase shifting and status word
module clock_manager_phase_status (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ref_clock_in,
  input wire logic i_feedback_clock_in,
  input wire logic i_phase_step_clock,
  input wire logic i_phase_step_request,
  input wire logic i_phase_step_direction,
  input wire logic [7:0] i_fixed_shift,
  input wire logic i_synth_hold,
  input wire logic i_legacy_mode,
  input wire logic i_reconfig_load,
  input wire logic [7:0] i_reconfig_phase,
  output clock_manager_pkg::clock_out_s o_clocks,
  output logic o_lock_done,
  output logic o_phase_step_done,
  output clock_manager_pkg::status_s o_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for everything arriving from outside the system clock
  logic [1:0] ref_sync, fb_sync, psc_sync, req_sync, dir_sync;
  logic ref_d, psc_d, req_d, dir_d;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_sync <= 2'h0;
      fb_sync <= 2'h0;
      psc_sync <= 2'h0;
      req_sync <= 2'h0;
      dir_sync <= 2'h0;
      ref_d <= 1'b0;
      psc_d <= 1'b0;
      req_d <= 1'b0;
      dir_d <= 1'b0;
    end else begin
      ref_sync <= {ref_sync[0], i_ref_clock_in};
      fb_sync <= {fb_sync[0], i_feedback_clock_in};
      psc_sync <= {psc_sync[0], i_phase_step_clock};
      req_sync <= {req_sync[0], i_phase_step_request};
      dir_sync <= {dir_sync[0], i_phase_step_direction};
      ref_d <= ref_sync[1];
      psc_d <= psc_sync[1];
      req_d <= req_sync[1];
      dir_d <= dir_sync[1];
    end
  end

  wire ref_rise = ref_sync[1] && !ref_d;
  // Request and direction as they stood just before the step clock edge
  wire ps_rise = psc_sync[1] && !psc_d;

  ////////////////////////////////////////////////////////////////////////////
  // Stop detection
  logic ref_stopped, fb_stopped, synth_stopped;
  logic [8:0] ref_quiet, fb_quiet, synth_quiet;

  stop_detector u_ref_stop (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_level(ref_sync[1]),
    .o_stopped(ref_stopped),
    .o_quiet_count(ref_quiet)
  );

  stop_detector u_fb_stop (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_level(fb_sync[1]),
    .o_stopped(fb_stopped),
    .o_quiet_count(fb_quiet)
  );

  stop_detector u_synth_stop (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_level(o_clocks.synth_clock_out),
    .o_stopped(synth_stopped),
    .o_quiet_count(synth_quiet)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lock sequence and reference period measurement
  clock_manager_pkg::lock_state_e lock_state;
  logic [7:0] lock_cnt, per_cnt, period, phase;
  wire lock_cnt_hit = (lock_state == clock_manager_pkg::LK_HOLD) ?
      (lock_cnt == clock_manager_pkg::LOCK_START_EDGES) :
      (lock_cnt == clock_manager_pkg::LOCK_EDGES);
  wire locked = lock_state == clock_manager_pkg::LK_LOCKED;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_state <= clock_manager_pkg::LK_HOLD;
      lock_cnt <= 8'h00;
    end else begin
      unique case (lock_state)
        clock_manager_pkg::LK_HOLD, clock_manager_pkg::LK_LOCKING: begin
          if (lock_cnt_hit) begin
            lock_cnt <= 8'h00;
            lock_state <= (lock_state == clock_manager_pkg::LK_HOLD) ?
                clock_manager_pkg::LK_LOCKING : clock_manager_pkg::LK_LOCKED;
          end else if (ref_rise) begin
            lock_cnt <= lock_cnt + 8'h01;
          end
        end
        clock_manager_pkg::LK_LOCKED: begin
          // A lost reference forces a fresh lock
          if (ref_stopped) begin
            lock_state <= clock_manager_pkg::LK_LOCKING;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      per_cnt <= 8'h00;
      period <= clock_manager_pkg::PERIOD_RST;
    end else if (ref_rise) begin
      per_cnt <= 8'h00;
      period <= per_cnt + 8'h01;
    end else if (per_cnt != 8'hFF) begin
      per_cnt <= per_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output clock synthesis from phase position within the reference period
  wire [15:0] shift_prod = period * phase;
  wire [7:0] shift_cyc = shift_prod[15:8];
  wire [7:0] half_per = {1'b0, period[7:1]};
  wire [7:0] quarter_per = {2'b00, period[7:2]};
  wire [8:0] pos_sum = {1'b0, per_cnt} + {1'b0, shift_cyc};
  wire [8:0] pos_wrap = pos_sum - {1'b0, period};
  wire [7:0] pos = (pos_sum >= {1'b0, period}) ? pos_wrap[7:0] : pos_sum[7:0];
  wire [7:0] pos_q = (pos >= quarter_per) ? pos - quarter_per :
      8'(pos + period - quarter_per);
  wire [7:0] pos_d = (pos >= half_per) ? pos - half_per : pos;
  wire next_base = pos < half_per;
  wire next_quarter = pos_q < half_per;
  wire next_double = pos_d < quarter_per;
  logic [1:0] synth_cnt;
  wire synth_flip = synth_cnt == clock_manager_pkg::SYNTH_HALF - 2'h1;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clocks <= '0;
      synth_cnt <= 2'h0;
    end else begin
      o_clocks.base_phase_out <= locked && next_base;
      o_clocks.quarter_phase_out <= locked && next_quarter;
      o_clocks.half_phase_out <= locked && !next_base;
      o_clocks.double_rate_out <= locked && next_double;
      synth_cnt <= synth_flip ? 2'h0 : synth_cnt + 2'h1;
      if (!locked) begin
        o_clocks.synth_clock_out <= 1'b0;
      end else if (synth_flip && !i_synth_hold) begin
        o_clocks.synth_clock_out <= !o_clocks.synth_clock_out;
      end
    end
  end

  assign o_lock_done = locked;

  ////////////////////////////////////////////////////////////////////////////
  // Variable phase step handshake
  clock_manager_pkg::ps_state_e ps_state;
  logic [4:0] ps_lat;
  logic step_dir, step_ovf;
  wire ps_idle = ps_state == clock_manager_pkg::PS_IDLE;
  wire step_take = ps_idle && ps_rise && req_d;
  wire at_limit = dir_d ? (phase == clock_manager_pkg::PHASE_MAX) :
      (phase == clock_manager_pkg::PHASE_MIN);
  wire step_apply = (ps_state == clock_manager_pkg::PS_BUSY) &&
      (ps_lat == clock_manager_pkg::PS_LATENCY);
  wire reconf_load = ps_idle && i_reconfig_load && !i_legacy_mode;
  wire ovf_set = step_take && at_limit;
  logic lock_start_d;
  wire strap_take = (lock_state == clock_manager_pkg::LK_HOLD) &&
      !lock_start_d;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ps_state <= clock_manager_pkg::PS_IDLE;
      ps_lat <= 5'h00;
      step_dir <= 1'b0;
      step_ovf <= 1'b0;
      o_phase_step_done <= 1'b0;
    end else begin
      unique case (ps_state)
        clock_manager_pkg::PS_IDLE: begin
          if (step_take) begin
            step_dir <= dir_d;
            step_ovf <= at_limit;
            ps_lat <= 5'h00;
            ps_state <= clock_manager_pkg::PS_BUSY;
          end
        end
        clock_manager_pkg::PS_BUSY: begin
          ps_lat <= ps_lat + 5'h01;
          if (step_apply) begin
            ps_state <= clock_manager_pkg::PS_DONE_WAIT;
          end
        end
        clock_manager_pkg::PS_DONE_WAIT: begin
          if (ps_rise) begin
            o_phase_step_done <= 1'b1;
            ps_state <= clock_manager_pkg::PS_DONE;
          end
        end
        clock_manager_pkg::PS_DONE: begin
          if (ps_rise) begin
            o_phase_step_done <= 1'b0;
            ps_state <= clock_manager_pkg::PS_IDLE;
          end
        end
      endcase
    end
  end

  // Fixed shift is a strap, caught once after reset release
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= clock_manager_pkg::PHASE_RST;
      lock_start_d <= 1'b0;
    end else begin
      lock_start_d <= 1'b1;
      if (strap_take) begin
        phase <= i_fixed_shift;
      end else if (step_apply && !step_ovf) begin
        phase <= step_dir ? phase + 8'h01 : phase - 8'h01;
      end else if (reconf_load) begin
        phase <= i_reconfig_phase;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag with minimum hold, counted in reference edges
  logic ovf;
  logic [5:0] ovf_cnt;
  wire ovf_expire = ref_rise &&
      (ovf_cnt == clock_manager_pkg::OVF_HOLD_EDGES - 6'h01);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovf <= 1'b0;
      ovf_cnt <= 6'h00;
    end else if (ovf_set) begin
      ovf <= 1'b1;
      ovf_cnt <= 6'h00;
    end else if (ovf && ref_rise) begin
      ovf_cnt <= ovf_cnt + 6'h01;
      ovf <= !ovf_expire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word
  clock_manager_pkg::status_s next_status;
  assign next_status.phase_hi = i_legacy_mode ? 8'h00 : phase;
  assign next_status.reserved = 4'h0;
  assign next_status.fb_stopped = fb_stopped;
  assign next_status.synth_stopped = synth_stopped;
  assign next_status.ref_stopped = ref_stopped;
  assign next_status.overflow = ovf;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status <= clock_manager_pkg::STATUS_RST;
    end else begin
      o_status <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  clocks_unlocked_a: assert property (!locked |=> o_clocks == '0)
    else $error("clock output active while unlocked");
  lock_order_a: assert property ($rose(lock_state ==
      clock_manager_pkg::LK_LOCKED) |-> $past(lock_state) ==
      clock_manager_pkg::LK_LOCKING)
    else $error("lock reached without locking phase");
  half_inverse_a: assert property (locked && $past(locked) |->
      o_clocks.half_phase_out == !o_clocks.base_phase_out)
    else $error("half phase output not inverse of base");
  done_release_a: assert property (o_phase_step_done && ps_rise |=>
      !o_phase_step_done)
    else $error("done held past one step clock period");
  done_stays_a: assert property (o_phase_step_done && !ps_rise |=>
      o_phase_step_done)
    else $error("done dropped before step clock edge");
  ovf_flag_a: assert property (ovf_set |-> ##2 o_status.overflow)
    else $error("overflow not flagged");
  ovf_keeps_a: assert property (step_apply && step_ovf &&
      !reconf_load |=> $stable(phase))
    else $error("phase moved on overflow");
  ovf_hold_a: assert property ($fell(ovf) |->
      $past(ovf_cnt) == clock_manager_pkg::OVF_HOLD_EDGES - 6'h01)
    else $error("overflow cleared too early");
  step_inc_a: assert property (step_apply && !step_ovf && step_dir |=>
      phase == $past(phase) + 8'h01)
    else $error("increment did not add one");
  step_dec_a: assert property (step_apply && !step_ovf && !step_dir |=>
      phase == $past(phase) - 8'h01)
    else $error("decrement did not subtract one");
  busy_ignore_a: assert property (!ps_idle && ps_rise && req_d &&
      ps_state != clock_manager_pkg::PS_DONE |=> !ps_idle)
    else $error("request accepted while busy");
  ref_stop_a: assert property ($rose(ref_stopped) |->
      $past(ref_quiet) == clock_manager_pkg::STOP_COUNT)
    else $error("reference stop flagged at wrong count");
  fb_stop_a: assert property ($rose(fb_stopped) |->
      $past(fb_quiet) == clock_manager_pkg::STOP_COUNT)
    else $error("feedback stop flagged at wrong count");
  synth_stop_a: assert property ($rose(synth_stopped) |->
      $past(synth_quiet) == clock_manager_pkg::STOP_COUNT)
    else $error("synth stop flagged at wrong count");
  legacy_upper_a: assert property (i_legacy_mode |=>
      o_status.phase_hi == 8'h00)
    else $error("upper status visible in legacy mode");
  legacy_port_a: assert property (i_legacy_mode && ps_idle &&
      !strap_take |=> $stable(phase))
    else $error("reconfiguration acted in legacy mode");

  lock_seen_c: cover property ($rose(locked));
  step_done_c: cover property ($rose(o_phase_step_done));
  overflow_c: cover property ($rose(o_status.overflow));
  ref_stop_c: cover property ($rose(o_status.ref_stopped));

endmodule : clock_manager_phase_status

// *** core/clock_manager_pkg.sv ***
// Constants, types and state enumerations of the clock manager
package clock_manager_pkg;

  localparam int MCLK_PERIOD_NS = 8;
  // Sync chain plus edge detect, in system clock cycles
  localparam int SYNC_LAT = 3;
  localparam int STOP_MIN_CYC = 257;
  localparam int STOP_MAX_CYC = 260;
  localparam logic [8:0] STOP_COUNT = 9'(STOP_MIN_CYC - SYNC_LAT);

  localparam logic [7:0] LOCK_START_EDGES = 8'h03;
  localparam logic [7:0] LOCK_EDGES = 8'h40;
  localparam logic [5:0] OVF_HOLD_EDGES = 6'h28;
  localparam logic [4:0] PS_LATENCY = 5'h10;
  localparam logic [1:0] SYNTH_HALF = 2'h2;

  localparam logic [7:0] PHASE_MAX = 8'hFF;
  localparam logic [7:0] PHASE_MIN = 8'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'h00;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  typedef struct packed {
    logic [7:0] phase_hi;
    logic [3:0] reserved;
    logic fb_stopped;
    logic synth_stopped;
    logic ref_stopped;
    logic overflow;
  } status_s;

  typedef struct packed {
    logic base_phase_out;
    logic quarter_phase_out;
    logic half_phase_out;
    logic double_rate_out;
    logic synth_clock_out;
  } clock_out_s;

  typedef enum logic [1:0] {
    LK_HOLD,
    LK_LOCKING,
    LK_LOCKED
  } lock_state_e;

  typedef enum logic [1:0] {
    PS_IDLE,
    PS_BUSY,
    PS_DONE_WAIT,
    PS_DONE
  } ps_state_e;

endpackage : clock_manager_pkg

// *** core/stop_detector.sv ***
// Watches a synchronised clock level and flags when it stops toggling
module stop_detector (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_level,
  output logic o_stopped,
  output logic [8:0] o_quiet_count
);

  logic prev;
  wire toggle = i_level != prev;
  wire at_limit = o_quiet_count == clock_manager_pkg::STOP_COUNT;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev <= 1'b0;
      o_quiet_count <= 9'h000;
      o_stopped <= 1'b0;
    end else begin
      prev <= i_level;
      // Counter saturates so a long stall never wraps and clears the flag
      if (toggle) begin
        o_quiet_count <= 9'h000;
      end else if (!at_limit) begin
        o_quiet_count <= o_quiet_count + 9'h001;
      end
      o_stopped <= !toggle && (at_limit || o_stopped);
    end
  end

endmodule : stop_detector

// *** verif/step_user_model.sv ***
// User logic model driving the phase step handshake
module step_user_model (
  input wire logic i_go,
  input wire logic i_dir,
  input wire logic i_early,
  input wire logic i_done,
  output logic o_step_clock,
  output logic o_request,
  output logic o_direction,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////
  // Step clock runs free; the block samples it on its own clock
  initial begin
    o_step_clock = 1'b0;
    forever #40 o_step_clock = ~o_step_clock;
  end

  task automatic edge_out();
    @(posedge o_step_clock);
    #1;
  endtask : edge_out

  ////////////////////////////////////////////////////////////
  initial begin
    o_request = 1'b0;
    o_direction = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_go);
      o_busy = 1'b1;
      edge_out();
      o_request = 1'b1;
      o_direction = i_dir;
      edge_out();
      o_request = 1'b0;
      // Inverted so a late sample of direction cannot pass unseen
      o_direction = ~o_direction;
      if (i_early) begin
        // Deliberate repeat while busy, which must be dropped
        edge_out();
        o_request = 1'b1;
        edge_out();
        o_request = 1'b0;
      end
      for (int i = 0; i < 20 && i_done !== 1'b1; i++) begin
        @(posedge o_step_clock);
      end
      for (int i = 0; i < 20 && i_done !== 1'b0; i++) begin
        @(posedge o_step_clock);
      end
      o_busy = 1'b0;
    end
  end
endmodule : step_user_model

// *** verif/clock_manager_phase_status_tb.sv ***
// Self-checking bench of the clock manager phase and status block
module clock_manager_phase_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, ref_clk, fb_clk, ref_run, fb_run, watch;
  logic ps_clk, ps_req, ps_dir, ps_done, lock_done, synth_hold, legacy;
  logic rc_load, go, go_dir, early, user_busy;
  logic [7:0] fixed_shift, rc_phase;
  logic [1:0] watch_sel;
  clock_manager_pkg::clock_out_s clocks;
  clock_manager_pkg::status_s status;
  int error_cnt = 0, comparisons = 0, done_len = 0, pulses = 0, quiet = 0;
  logic done_q = 1'b0, watch_q = 1'b0;

  assign watch = (watch_sel == 2'h0) ? clocks.synth_clock_out :
                 (watch_sel == 2'h1) ? fb_clk : ref_clk;

  clock_manager_phase_status clock_manager_phase_status_inst (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_ref_clock_in(ref_clk),
    .i_feedback_clock_in(fb_clk), .i_phase_step_clock(ps_clk),
    .i_phase_step_request(ps_req), .i_phase_step_direction(ps_dir),
    .i_fixed_shift(fixed_shift), .i_synth_hold(synth_hold),
    .i_legacy_mode(legacy), .i_reconfig_load(rc_load),
    .i_reconfig_phase(rc_phase), .o_clocks(clocks),
    .o_lock_done(lock_done), .o_phase_step_done(ps_done),
    .o_status(status));

  step_user_model step_user_model_inst (.i_go(go), .i_dir(go_dir),
    .i_early(early), .i_done(ps_done), .o_step_clock(ps_clk),
    .o_request(ps_req), .o_direction(ps_dir), .o_busy(user_busy));

  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Offset start keeps the reference and feedback clock edges off the system clock edges
  initial begin
    ref_clk = 1'b0;
    fb_clk = 1'b0;
    #13;
    forever begin
      #40;
      if (ref_run) ref_clk = ~ref_clk;
      if (fb_run) fb_clk = ~fb_clk;
    end
  end

  // Done pulse length, pulse count and quiet time of the watched clock
  always @(posedge mclk) begin
    if (ps_done === 1'b1 && done_q !== 1'b1) begin
      pulses++;
      done_len = 1;
    end else if (ps_done === 1'b1) begin
      done_len++;
    end
    done_q = ps_done;
    // The first edge that sees the change already counts as one quiet cycle
    quiet = (watch !== watch_q) ? 1 : quiet + 1;
    watch_q = watch;
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic load(input logic [7:0] v);
    rc_phase = v;
    rc_load = 1'b1;
    cyc(1);
    rc_load = 1'b0;
    cyc(3);
  endtask : load

  task automatic t_reset();
    @(posedge mclk);
    #2 rst_n = 1'b0;
    #1 check("clocks at reset", 16'(clocks), 16'h0000);
    check("lock at reset", 16'(lock_done), 16'h0000);
    cyc(40);
    check("clocks in reset", 16'(clocks), 16'h0000);
    rst_n = 1'b1;
    for (int i = 0; i < 1000 && lock_done !== 1'b1; i++) cyc(1);
    check("lock done", 16'(lock_done), 16'h0001);
    $display("reset test over");
  endtask : t_reset

  task automatic step(input logic dir, input logic two,
      input logic [7:0] exp, input logic ovf);
    pulses = 0;
    go_dir = dir;
    early = two;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (int i = 0; i < 500 && user_busy; i++) cyc(1);
    cyc(4);
    check("phase", 16'(status.phase_hi), 16'(exp));
    check("overflow", 16'(status.overflow), 16'(ovf));
    check("done pulses", 16'(pulses), 16'h0001);
    check("done width", 16'(done_len >= 9 && done_len <= 11),
      16'h0001);
  endtask : step

  task automatic t_steps();
    check("start phase", 16'(status.phase_hi), 16'h0040);
    step(1'b1, 1'b0, 8'h41, 1'b0);
    step(1'b0, 1'b0, 8'h40, 1'b0);
    step(1'b1, 1'b1, 8'h41, 1'b0);
    $display("step test over");
  endtask : t_steps

  // Base, quarter, half and double outputs over ten reference periods
  task automatic t_outputs();
    int base_up = 0, dbl_up = 0, quarter_hi = 0, differ = 0;
    clock_manager_pkg::clock_out_s prev;
    prev = clocks;
    for (int i = 0; i < 100; i++) begin
      cyc(1);
      base_up += clocks.base_phase_out && !prev.base_phase_out;
      dbl_up += clocks.double_rate_out && !prev.double_rate_out;
      quarter_hi += clocks.quarter_phase_out;
      differ += clocks.half_phase_out !== clocks.base_phase_out;
      prev = clocks;
    end
    check("base rises", 16'(base_up), 16'h000A);
    check("double rises", 16'(dbl_up), 16'h0014);
    check("quarter high", 16'(quarter_hi), 16'h0032);
    check("half against base", 16'(differ), 16'h0064);
    $display("output test over");
  endtask : t_outputs

  task automatic t_overflow();
    load(8'hFF);
    step(1'b1, 1'b0, 8'hFF, 1'b1);
    repeat (32) @(posedge ref_clk);
    cyc(1);
    check("overflow held", 16'(status.overflow), 16'h0001);
    load(8'h00);
    step(1'b0, 1'b0, 8'h00, 1'b1);
    repeat (45) @(posedge ref_clk);
    cyc(1);
    check("overflow cleared", 16'(status.overflow), 16'h0000);
    $display("overflow test over");
  endtask : t_overflow

  task automatic t_legacy();
    legacy = 1'b1;
    cyc(3);
    check("upper status", 16'(status.phase_hi), 16'h0000);
    load(8'h22);
    legacy = 1'b0;
    cyc(3);
    check("phase kept", 16'(status.phase_hi), 16'h0000);
    $display("legacy test over");
  endtask : t_legacy

  task automatic stop_one(input logic [1:0] sel, input int b);
    watch_sel = sel;
    cyc(2);
    synth_hold = (sel == 2'h0);
    fb_run = (sel != 2'h1);
    ref_run = (sel != 2'h2);
    for (int i = 0; i < 400 && status[b] !== 1'b1; i++) cyc(1);
    check("stop delay", 16'(quiet >= 257 && quiet <= 260),
      16'h0001);
    synth_hold = 1'b0;
    fb_run = 1'b1;
    ref_run = 1'b1;
    cyc(20);
    check("stop cleared", 16'(status[b]), 16'h0000);
  endtask : stop_one

  task automatic t_stops();
    stop_one(2'h0, 2);
    stop_one(2'h1, 3);
    stop_one(2'h2, 1);
    $display("stop test over");
  endtask : t_stops

  ////////////////////////////////////////////////////////////
  initial begin
    #200us;
    error_cnt++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    ref_run = 1'b1;
    fb_run = 1'b1;
    go = 1'b0;
    go_dir = 1'b0;
    early = 1'b0;
    fixed_shift = 8'h40;
    synth_hold = 1'b0;
    legacy = 1'b0;
    rc_load = 1'b0;
    rc_phase = 8'h00;
    watch_sel = 2'h0;
    t_reset();
    // Second reset lands while locked
    t_reset();
    t_steps();
    t_outputs();
    t_overflow();
    t_legacy();
    t_stops();
    give_verdict();
  end
endmodule : clock_manager_phase_status_tb
